// ==== verilog/sfr_pkg.sv ====
/*
 * Constants for the self-test sequencer and fault indicator reporter:
 * maintenance test numbers, front panel error codes, indicator timing.
 * Assumes a 100 MHz system clock; the blink cycle count below is derived from it.
 */
package sfr_pkg;
    // Maintenance test numbers carried in the upper byte of command word three.
    localparam logic [7:0] TEST_ALL     = 8'h40;
    localparam logic [7:0] TEST_FIRST   = 8'h41;
    localparam logic [7:0] TEST_LAST    = 8'h50;
    localparam logic [7:0] PERIPH_FIRST = 8'h7C;
    localparam logic [7:0] PERIPH_LAST  = 8'h7F;
    localparam int         CODE_BYTE_LSB = 8;

    // Peripheral memory operations, in the order of codes 7C to 7F.
    typedef enum logic [1:0] {
        PO_READ_PARAM,
        PO_EXEC,
        PO_WRITE,
        PO_READ
    } sfr_periph_e;

    // Front panel error codes.
    localparam logic [3:0] ERR_CPU_A     = 4'h0;
    localparam logic [3:0] ERR_CPU_B     = 4'h1;
    localparam logic [3:0] ERR_CPU_C     = 4'h2;
    localparam logic [3:0] ERR_TAPE_CTRL = 4'h3;
    localparam logic [3:0] ERR_TAPE_ENC  = 4'h4;
    localparam logic [3:0] ERR_TAPE_DRV  = 4'h5;
    localparam logic [3:0] ERR_TAPE_NONE = 4'h6;
    localparam logic [3:0] ERR_HS_DATA   = 4'h8;
    localparam logic [3:0] ERR_SERVO     = 4'h9;
    localparam logic [3:0] ERR_READ      = 4'hA;
    localparam logic [3:0] ERR_WRITE     = 4'hB;
    localparam logic [3:0] ERR_NO_DISK   = 4'hC;
    localparam logic [3:0] ERR_NO_LINK   = 4'hE;
    localparam logic [3:0] ERR_NONE      = 4'hF;

    // Indicator blink timing: one half period of the common blink.
    localparam int CLK_PERIOD_NS  = 10;
    localparam int BLINK_HALF_NS  = 250_000_000;
    localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;

    // Depth of the chassis error code queue.
    localparam int ERR_DEPTH = 8;
endpackage

// ==== verilog/sfr_top.sv ====
/*
 * Self-test sequencing and fault indicator logic for the host interface
 * board and the storage chassis it serves. Assumes every input is
 * synchronous to clk_i and that the switch input is already debounced.
 */
`timescale 1ns/1ps

// Summary of operation
// - Fault indicator lights when any board self-test run begins.
// - Fault indicator clears only on a run with no errors; else stays steady.
// - A peripheral-link error during operation makes the fault indicator blink.
// - Host-bus indicator is lit while bus access works, dark when it fails.
// - Each activity indicator lights while its slave set's idle bit is zero.
// - Test number is taken from the upper byte of command word three.
// - Code 40 runs all board tests; 41 to 50 select one test.
// - Codes 7C to 7F are the four peripheral memory operations.
// - Chassis self-test runs after power-up and every system reset.
// - Errors show as four-bit codes; 1111 means no error.
// - Each upward switch actuation steps to the next recorded error code.
// - After 1111 is shown the next actuation restores normal status.
// - Codes 0000 to 0010 report processor, board or power failures.
// - Tape failures use codes 0011, 0100, 0101 and 0110.
// - Disk failures use codes 1000, 1001, 1010, 1011 and 1100.
// - Code 1110 reports a missing host link or interface board.
// - Larger variant reports 1001 on first power-up with uninitialised disk.
// - Disk-ready blinks during disk test, steady on pass, off on failure.
// - Tape-ready load blink waits until the test mode indicator is off.
// - Switch actuations are ignored while host tape activity runs.
module sfr_top #(
    parameter int BLINK_HALF = sfr_pkg::BLINK_HALF_CYC,
    parameter int DEPTH      = sfr_pkg::ERR_DEPTH,
    parameter bit LARGE_DISK = 1'b0
) (
    // Clock and reset.
    input  wire logic                clk_i,
    input  wire logic                reset_i,
    // Host command and interface board test engine.
    input  wire logic                cmd_valid_i,
    input  wire logic [15:0]         cmd_word_three_i,
    input  wire logic                board_done_i,
    input  wire logic                board_fail_i,
    input  wire logic                link_error_i,
    input  wire logic                bus_access_ok_i,
    input  wire logic [1:0]          slave_idle_i,
    output logic                     board_go_o,
    output logic                     board_all_o,
    output logic [3:0]               board_sel_o,
    output logic                     periph_go_o,
    output sfr_pkg::sfr_periph_e     periph_op_o,
    output logic                     cmd_bad_o,
    // Board indicators.
    output logic                     fault_led_o,
    output logic                     bus_led_o,
    output logic [1:0]               busy_led_o,
    // Chassis test engine.
    input  wire logic                sys_reset_i,
    input  wire logic                err_valid_i,
    input  wire logic [3:0]          err_code_i,
    input  wire logic                chassis_done_i,
    input  wire logic                link_absent_i,
    input  wire logic                disk_uninit_i,
    output logic                     chassis_go_o,
    // Front panel.
    input  wire logic                switch_up_i,
    input  wire logic                tape_busy_i,
    input  wire logic                disk_test_i,
    input  wire logic                disk_done_i,
    input  wire logic                disk_pass_i,
    input  wire logic                tape_loading_i,
    input  wire logic                tape_ready_i,
    output logic                     show_errors_o,
    output logic [3:0]               panel_code_o,
    output logic                     test_mode_led_o,
    output logic                     disk_led_o,
    output logic                     tape_led_o
);
    import sfr_pkg::*;

    initial begin
        if (BLINK_HALF < 1 || DEPTH < 2 || DEPTH > 16) begin
            $error("sfr_top: unsupported parameter values");
        end
    end

    typedef enum logic [1:0] {FL_OFF, FL_TESTING, FL_FAILED} sfr_fault_e;
    localparam int QW = $clog2(DEPTH + 1);

    sfr_fault_e        fault_state;
    logic              link_warn;
    logic [31:0]       blink_cnt;
    logic              blink;
    logic              boot;
    logic              switch_prev;
    logic [QW-1:0]     err_cnt;
    logic [QW-1:0]     rd_idx;
    logic [3:0]        err_mem [DEPTH];
    logic              disk_ok;

    // Command decode from the upper byte of command word three.
    wire [7:0] test_code = cmd_word_three_i[CODE_BYTE_LSB +: 8];
    wire       is_all    = (test_code == TEST_ALL);
    wire       is_one    = (test_code >= TEST_FIRST) && (test_code <= TEST_LAST);
    wire       is_perh   = (test_code >= PERIPH_FIRST) && (test_code <= PERIPH_LAST);
    wire [7:0] sel_off   = test_code - TEST_FIRST;
    wire       run_start = cmd_valid_i && (is_all || is_one);

    // Front panel stepping; tape activity masks the switch entirely.
    wire sw_edge   = switch_up_i && !switch_prev && !tape_busy_i;
    wire chs_start = boot || sys_reset_i;
    wire q_full    = (err_cnt == QW'(DEPTH));
    wire [3:0] cur_code = (rd_idx < err_cnt) ? err_mem[rd_idx[$clog2(DEPTH)-1:0]]
                                              : ERR_NONE;
    wire blink_tick = (blink_cnt == 32'(BLINK_HALF - 1));

    // End of run appends one code: link-absent if flagged, else uninitialised-disk (LARGE_DISK only).
    wire       add_link = chassis_done_i && link_absent_i;
    wire       add_disk = chassis_done_i && disk_uninit_i && LARGE_DISK;
    wire       push     = (err_valid_i || add_link || add_disk) && !q_full;
    wire [3:0] push_code = err_valid_i ? err_code_i :
                           add_link ? ERR_NO_LINK : ERR_SERVO;

    // One free-running divider paces every blinking indicator, so they
    // all flash in step and an operator never sees two rates.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            blink_cnt <= '0;
            blink     <= 1'b0;
        end else begin
            blink_cnt <= blink_tick ? '0 : blink_cnt + 32'h1;
            if (blink_tick) begin
                blink <= !blink;
            end
        end
    end

    // Go and bad outputs are registered pulses so the test engine sees clean strobes; all, select and op hold until the next command.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            board_go_o  <= 1'b0;
            board_all_o <= 1'b0;
            board_sel_o <= 4'h0;
            periph_go_o <= 1'b0;
            periph_op_o <= PO_READ_PARAM;
            cmd_bad_o   <= 1'b0;
        end else begin
            board_go_o  <= run_start;
            periph_go_o <= cmd_valid_i && is_perh;
            cmd_bad_o   <= cmd_valid_i && !(is_all || is_one || is_perh);
            if (cmd_valid_i) begin
                board_all_o <= is_all;
                board_sel_o <= is_one ? sel_off[3:0] : 4'h0;
                periph_op_o <= sfr_periph_e'(test_code[1:0]);
            end
        end
    end

    // Fault indicator. A start always wins over a completion in the same cycle.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            fault_state <= FL_OFF;
            link_warn   <= 1'b0;
        end else begin
            if (run_start) begin
                fault_state <= FL_TESTING;
                link_warn   <= link_error_i;
            end else begin
                if (board_done_i && fault_state == FL_TESTING) begin
                    fault_state <= board_fail_i ? FL_FAILED : FL_OFF;
                end
                if (link_error_i) begin
                    link_warn <= 1'b1;
                end
            end
        end
    end

    // Board indicators, all registered.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            fault_led_o <= 1'b0;
            bus_led_o   <= 1'b0;
            busy_led_o  <= 2'b00;
        end else begin
            fault_led_o <= (fault_state != FL_OFF) || (link_warn && blink);
            bus_led_o   <= bus_access_ok_i;
            busy_led_o  <= ~slave_idle_i;
        end
    end

    // Chassis run control: the boot flag fires one run after reset release.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            boot            <= 1'b1;
            chassis_go_o    <= 1'b0;
            test_mode_led_o <= 1'b0;
        end else begin
            boot         <= 1'b0;
            chassis_go_o <= chs_start;
            if (chs_start) begin
                test_mode_led_o <= 1'b1;
            end else if (chassis_done_i) begin
                test_mode_led_o <= 1'b0;
            end
        end
    end

    // Error queue: a new run empties it, codes are kept in arrival order,
    // and the terminator is implied once the read index reaches the count.
    always_ff @(posedge clk_i) begin
        if (reset_i || chs_start) begin
            err_cnt <= '0;
        end else if (push) begin
            err_cnt <= err_cnt + QW'(1);
        end
    end

    for (genvar i = 0; i < DEPTH; i++) begin : g_slot
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                err_mem[i] <= ERR_NONE;
            end else if (push && err_cnt == QW'(i)) begin
                err_mem[i] <= push_code;
            end
        end
    end

    // Panel display stepping on each upward switch actuation.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            switch_prev   <= 1'b0;
            rd_idx        <= '0;
            show_errors_o <= 1'b0;
            panel_code_o  <= ERR_NONE;
        end else begin
            switch_prev <= switch_up_i;
            if (sw_edge) begin
                if (!show_errors_o) begin
                    show_errors_o <= 1'b1;
                    rd_idx        <= '0;
                end else if (cur_code == ERR_NONE) begin
                    show_errors_o <= 1'b0;
                end else begin
                    rd_idx <= rd_idx + QW'(1);
                end
            end
            panel_code_o <= cur_code;
        end
    end

    // Disk and tape ready indicators.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            disk_ok    <= 1'b0;
            disk_led_o <= 1'b0;
            tape_led_o <= 1'b0;
        end else begin
            if (disk_test_i) begin
                disk_ok <= 1'b0;
            end else if (disk_done_i) begin
                disk_ok <= disk_pass_i;
            end
            disk_led_o <= disk_test_i ? blink : disk_ok;
            tape_led_o <= tape_ready_i ||
                          (tape_loading_i && !test_mode_led_o && blink);
        end
    end

    // Checks on the logic above.
    a_fault_on_start: assert property (@(posedge clk_i) disable iff (reset_i)
        run_start |=> ##1 fault_led_o)
        else $error("fault indicator not lit after run start");

    a_fault_stays_lit: assert property (@(posedge clk_i) disable iff (reset_i)
        (fault_state == FL_TESTING && board_done_i && board_fail_i && !run_start)
        |=> ##1 fault_led_o [*3])
        else $error("fault indicator not steady after failed run");

    a_bus_led_follow: assert property (@(posedge clk_i) disable iff (reset_i)
        !$past(reset_i) |-> bus_led_o == $past(bus_access_ok_i))
        else $error("host bus indicator does not follow access state");

    a_busy_led_follow: assert property (@(posedge clk_i) disable iff (reset_i)
        !$past(reset_i) |-> busy_led_o == ~$past(slave_idle_i))
        else $error("activity indicator does not follow idle bits");

    a_test_all_decode: assert property (@(posedge clk_i) disable iff (reset_i)
        (cmd_valid_i && cmd_word_three_i[15:8] == 8'h40)
        |=> board_go_o && board_all_o)
        else $error("code 40 did not start all tests");

    a_periph_decode: assert property (@(posedge clk_i) disable iff (reset_i)
        (cmd_valid_i && cmd_word_three_i[15:8] == 8'h7E)
        |=> periph_go_o && periph_op_o == PO_WRITE && !board_go_o)
        else $error("code 7E not decoded as peripheral write");

    a_chassis_boot: assert property (@(posedge clk_i)
        $fell(reset_i) |=> chassis_go_o ##1 test_mode_led_o)
        else $error("chassis test not started after reset");

    a_switch_masked: assert property (@(posedge clk_i) disable iff (reset_i)
        (tape_busy_i && !chs_start) |=> $stable(rd_idx) && $stable(show_errors_o))
        else $error("switch acted during tape activity");

    a_end_restores: assert property (@(posedge clk_i) disable iff (reset_i)
        (sw_edge && show_errors_o && cur_code == ERR_NONE) |=> !show_errors_o)
        else $error("normal status not restored after terminator");

    a_disk_fail_dark: assert property (@(posedge clk_i) disable iff (reset_i)
        (disk_done_i && !disk_pass_i && !disk_test_i) ##1 !disk_test_i |=> !disk_led_o)
        else $error("disk indicator lit after failed disk test");
endmodule

// ==== verification/sfr_host_model.sv ====
/*
 * Host-side model of the board test engine: it answers each board run start
 * with a done pulse after a fixed delay unless a newer start restarts the count. Assumes the block's clock.
 */
`timescale 1ns/1ps
module sfr_host_model #(
    parameter int DELAY = 6
) (
    // Clock and verdict control.
    input  wire logic clk_i,
    input  wire logic fail_i,
    // Run handshake.
    input  wire logic board_go_i,
    output logic      board_done_o = 1'b0,
    output logic      board_fail_o = 1'b0
);
    int cnt = 0;

    // A new start restarts the count; the verdict only means something with done.
    always_ff @(posedge clk_i) begin
        board_done_o <= (cnt == 1);
        board_fail_o <= (cnt == 1) ? fail_i : ~board_fail_o;
        if (board_go_i)
            cnt <= DELAY;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
endmodule

// ==== verification/sfr_top_tb.sv ====
/*
 * Self-checking bench for the self-test and fault indicator block.
 * Assumes the host model answers board runs; blink half period shortened.
 */
`timescale 1ns/1ps
module sfr_top_tb;
    import sfr_pkg::*;
    logic clk_i = 1'b0, reset_i = 1'b1, fail_mode = 1'b0;
    logic cmd_valid_i = 1'b0, link_error_i = 1'b0, bus_access_ok_i = 1'b1;
    logic [15:0] cmd_word_three_i = 16'h0000;
    logic [1:0] slave_idle_i = 2'h3, busy_led_o;
    logic sys_reset_i = 1'b0, err_valid_i = 1'b0, chassis_done_i = 1'b0;
    logic [3:0] err_code_i = 4'h0, board_sel_o, panel_code_o;
    logic link_absent_i = 1'b0, disk_uninit_i = 1'b0, switch_up_i = 1'b0;
    logic tape_busy_i = 1'b0, disk_test_i = 1'b0, disk_done_i = 1'b0;
    logic disk_pass_i = 1'b0, tape_loading_i = 1'b0, tape_ready_i = 1'b0;
    logic board_done_i, board_fail_i, board_go_o, board_all_o, periph_go_o;
    logic cmd_bad_o, fault_led_o, bus_led_o, chassis_go_o, show_errors_o;
    logic test_mode_led_o, disk_led_o, tape_led_o;
    sfr_periph_e periph_op_o;
    int error_cnt = 0, compares = 0, t;

    // Short blink and a deep queue keep the run brief and the codes undropped.
    sfr_top #(.BLINK_HALF(4), .DEPTH(16), .LARGE_DISK(1'b1)) i_sfr_top (.clk_i, .reset_i,
        .cmd_valid_i,
        .cmd_word_three_i, .board_done_i, .board_fail_i, .link_error_i,
        .bus_access_ok_i, .slave_idle_i, .board_go_o, .board_all_o, .board_sel_o,
        .periph_go_o, .periph_op_o, .cmd_bad_o, .fault_led_o, .bus_led_o,
        .busy_led_o, .sys_reset_i, .err_valid_i, .err_code_i, .chassis_done_i,
        .link_absent_i, .disk_uninit_i, .chassis_go_o, .switch_up_i, .tape_busy_i,
        .disk_test_i, .disk_done_i, .disk_pass_i, .tape_loading_i, .tape_ready_i,
        .show_errors_o, .panel_code_o, .test_mode_led_o, .disk_led_o, .tape_led_o);
    sfr_host_model i_sfr_host_model (.clk_i, .fail_i(fail_mode), .board_go_i(board_go_o),
        .board_done_o(board_done_i), .board_fail_o(board_fail_i));

    // Free-running system clock.
    always #5 clk_i = ~clk_i;

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // Counts indicator changes over n cycles; a steady indicator gives zero.
    task automatic count(input int n, output int c);
        logic last;
        c = 0;
        last = fault_led_o ^ disk_led_o ^ tape_led_o;
        repeat (n) begin
            @(negedge clk_i);
            c += int'((fault_led_o ^ disk_led_o ^ tape_led_o) != last);
            last = fault_led_o ^ disk_led_o ^ tape_led_o;
        end
    endtask

    task automatic cmd(input logic [15:0] w, input logic [2:0] exp);
        @(posedge clk_i);
        cmd_valid_i <= 1'b1;
        cmd_word_three_i <= w;
        @(posedge clk_i);
        cmd_valid_i <= 1'b0;
        @(negedge clk_i);
        chk("go_periph_bad", {13'h0, exp}, {13'h0, board_go_o, periph_go_o, cmd_bad_o});
    endtask

    task automatic press(input logic show, input logic [3:0] code);
        @(posedge clk_i);
        switch_up_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        switch_up_i <= 1'b0;
        @(negedge clk_i);
        chk("show", {15'h0, show}, {15'h0, show_errors_o});
        if (show)
            chk("panel code", {12'h0, code}, {12'h0, panel_code_o});
    endtask

    task automatic wait_run();
        for (int i = 0; i < 4 && chassis_go_o !== 1'b1; i++)
            @(negedge clk_i);
        chk("chassis go", 16'h1, {15'h0, chassis_go_o});
        tick(1);
        chk("test mode", 16'h1, {15'h0, test_mode_led_o});
        // A tape load during the chassis run must not blink yet.
        @(posedge clk_i);
        tape_loading_i <= 1'b1;
        count(10, t);
        chk("tape held", 16'h0, {15'h0, tape_led_o});
        chk("tape held", 16'h0, 16'(t));
        @(posedge clk_i);
        tape_loading_i <= 1'b0;
    endtask

    // Queue codes, end the run, then step the panel through the list.
    task automatic chassis(input logic [3:0] q[$], input logic absent, input logic uninit);
        foreach (q[i]) begin
            @(posedge clk_i);
            err_valid_i <= 1'b1;
            err_code_i <= q[i];
        end
        @(posedge clk_i);
        err_valid_i <= 1'b0;
        chassis_done_i <= 1'b1;
        link_absent_i <= absent;
        disk_uninit_i <= uninit;
        @(posedge clk_i);
        chassis_done_i <= 1'b0;
        link_absent_i <= 1'b0;
        disk_uninit_i <= 1'b0;
        tick(2);
        chk("test mode off", 16'h0, {15'h0, test_mode_led_o});
        foreach (q[i]) press(1'b1, q[i]);
        if (absent) press(1'b1, ERR_NO_LINK);
        if (uninit) press(1'b1, ERR_SERVO);
        press(1'b1, ERR_NONE);
        @(posedge clk_i);
        tape_busy_i <= 1'b1;
        press(1'b1, ERR_NONE);
        @(posedge clk_i);
        tape_busy_i <= 1'b0;
        press(1'b0, ERR_NONE);
    endtask

    task automatic t_cmds();
        cmd(16'h40A5, 3'h4);
        chk("all", 16'h1, {15'h0, board_all_o});
        cmd(16'h4200, 3'h4);
        chk("sel", 16'h1, {12'h0, board_sel_o});
        cmd(16'h5000, 3'h4);
        chk("sel", 16'hF, {12'h0, board_sel_o});
        for (int i = 0; i < 4; i++) begin
            cmd({PERIPH_FIRST + 8'(i), 8'h00}, 3'h2);
            chk("op", 16'(i), {14'h0, periph_op_o});
        end
        cmd(16'h0040, 3'h1);
        cmd(16'h5100, 3'h1);
        cmd(16'h7B00, 3'h1);
        cmd(16'h8000, 3'h1);
        tick(12);
    endtask

    task automatic t_fault(input logic fail);
        fail_mode = fail;
        cmd(16'h4000, 3'h4);
        tick(1);
        chk("fault on", 16'h1, {15'h0, fault_led_o});
        tick(12);
        chk("fault after", {15'h0, fail}, {15'h0, fault_led_o});
    endtask

    task automatic t_blink();
        @(posedge clk_i);
        link_error_i <= 1'b1;
        @(posedge clk_i);
        link_error_i <= 1'b0;
        count(24, t);
        chk("blink", 16'h1, {15'h0, t >= 5 && t <= 7});
        t_fault(1'b0);
        count(12, t);
        chk("blink cleared", 16'h0, 16'(t));
    endtask

    task automatic t_leds(input logic ok, input logic [1:0] idle);
        @(posedge clk_i);
        bus_access_ok_i <= ok;
        slave_idle_i <= idle;
        tick(2);
        chk("bus led", {15'h0, ok}, {15'h0, bus_led_o});
        chk("busy leds", {14'h0, ~idle}, {14'h0, busy_led_o});
    endtask

    task automatic t_disk(input logic pass);
        @(posedge clk_i);
        disk_test_i <= 1'b1;
        count(24, t);
        chk("disk blink", 16'h1, {15'h0, t >= 5 && t <= 7});
        @(posedge clk_i);
        disk_test_i <= 1'b0;
        disk_done_i <= 1'b1;
        disk_pass_i <= pass;
        @(posedge clk_i);
        disk_done_i <= 1'b0;
        tick(2);
        count(10, t);
        chk("disk result", {15'h0, pass}, {15'h0, disk_led_o});
        chk("disk steady", 16'h0, 16'(t));
    endtask

    // Tape load blinks once test mode is off; ready is steady.
    task automatic t_tape();
        @(posedge clk_i);
        tape_loading_i <= 1'b1;
        count(24, t);
        chk("tape blink", 16'h1, {15'h0, t >= 5 && t <= 7});
        @(posedge clk_i);
        tape_loading_i <= 1'b0;
        tape_ready_i <= 1'b1;
        tick(2);
        chk("tape ready", 16'h1, {15'h0, tape_led_o});
        @(posedge clk_i);
        tape_ready_i <= 1'b0;
    endtask

    task automatic results();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Main sequence: reset, then every scenario in turn.
    initial begin
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        @(negedge clk_i);
        chk("panel idle", {12'h0, ERR_NONE}, {12'h0, panel_code_o});
        wait_run();
        chassis('{ERR_TAPE_CTRL, ERR_READ}, 1'b1, 1'b0);
        t_cmds();
        t_fault(1'b1);
        t_fault(1'b0);
        t_blink();
        t_leds(1'b0, 2'h2);
        t_leds(1'b1, 2'h1);
        t_disk(1'b1);
        t_disk(1'b0);
        t_tape();
        @(posedge clk_i);
        sys_reset_i <= 1'b1;
        @(posedge clk_i);
        sys_reset_i <= 1'b0;
        wait_run();
        chassis('{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hB,
            4'hC}, 1'b0, 1'b1);
        results();
    end

    // Watchdog: the whole sequence needs well under 2000 cycles.
    initial begin
        #50us;
        error_cnt++;
        results();
    end
endmodule
